// file: include/dwb_cfg.svh
// offsets, field positions, reset values and codes of the write-burst block
`ifndef DWB_CFG_SVH
`define DWB_CFG_SVH

// register byte offsets
`define DWB_OFS_MODE 32'h0000_0000
`define DWB_OFS_STATUS 32'h0000_0004
`define DWB_OFS_BANK 32'h0000_0008
`define DWB_OFS_ARR_ADDR 32'h0000_000C
`define DWB_OFS_ARR_DATA 32'h0000_0010
`define DWB_OFS_BEATS 32'h0000_0014

// mode register fields
`define DWB_MODE_BL_LSB 0
`define DWB_MODE_DM_EN 2
`define DWB_MODE_DBI_EN 3
`define DWB_MODE_CRC_EN 4
`define DWB_MODE_DLL_LOCK 5
`define DWB_MODE_PRE2 6
`define DWB_MODE_AL_LSB 8
`define DWB_MODE_CWL_LSB 16
`define DWB_MODE_RST 32'h0009_0000

// burst-length field codes and last-beat indices
`define DWB_BL_FIXED8 2'h0
`define DWB_BL_OTF 2'h1
`define DWB_BL_FIXED4 2'h2
`define DWB_LAST_BL8 3'h7
`define DWB_LAST_BC4 3'h3

// highest write latency that two-clock preamble forbids
`define DWB_CWL_MIN 5'h09

// status register fields
`define DWB_ST_BUSY 0
`define DWB_ST_BL8 1
`define DWB_ST_AUTOPRE 2
`define DWB_ST_CRC_PERS 3
`define DWB_ST_CRC_NONP 4
`define DWB_ST_OVFL 5
`define DWB_ST_CONFLICT 6
`define DWB_ST_CWL_BAD 7
`define DWB_ST_BANK_LSB 8
`define DWB_ST_RECOV_LSB 16
`define DWB_ST_IGNORED 24

`endif

// file: include/dwb_pkg.sv
// types shared by the write-burst block
package dwb_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LAT = 4'h2,
        ST_DATA = 4'h4,
        ST_REC = 4'h8
    } dwb_state_e;

    typedef struct packed {
        logic [5:0] addr;
        logic [1:0] be;
        logic [15:0] data;
    } dwb_beat_s;

    typedef logic [2:0] dwb_reg_t;
endpackage

// file: test/ddr_write_burst_control_bench.sv
// self-checking bench for the write-burst block against a controller model
`timescale 1ns/1ps
`default_nettype none
`include "dwb_cfg.svh"
module ddr_write_burst_control_bench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, ba, lane_ctl_n;
    logic [2:0] hsize;
    logic ck, wr_cmd_n, a10, a12, dqs;
    logic [5:0] col;
    logic [15:0] dq;
    logic [15:0] exp_mem [64];
    int n_mismatch, checks_done, cyc;

    // bus clock and cycle ceiling against hangs
    initial hclk = 1'b0;
    always #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end

    dwb_write_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ck(ck), .wr_cmd_n(wr_cmd_n), .ba(ba), .col(col), .a10(a10),
        .a12(a12), .dqs(dqs), .dq(dq), .lane_ctl_n(lane_ctl_n));
    dwb_ctl_model ctl (.ck(ck), .wr_cmd_n(wr_cmd_n), .ba(ba), .col(col), .a10(a10), .a12(a12),
        .dqs(dqs), .dq(dq), .lane_ctl_n(lane_ctl_n));

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one ahb-lite single transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask
    // array word lags its address by one cycle, hence the wait
    task automatic chk_arr(input int c);
        logic [31:0] r;
        for (int k = 0; k < 8; k++) begin
            wr(`DWB_OFS_ARR_ADDR, 32'(c + k));
            repeat (2) @(posedge hclk);
            rd(`DWB_OFS_ARR_DATA, r);
            chk("array", {16'h0, exp_mem[c + k]}, r);
        end
    endtask

    // one write burst with the model's expected array, status and beat count
    task automatic do_burst(input int bl, input int x10, input int x12, input int bk, input int c,
                            input int mm, input int al, input int cwl, input int dll, input int stall);
        logic [127:0] d;
        logic [15:0] m;
        logic [31:0] st, s2, b0, b1;
        logic [7:0] lb;
        int n;
        for (int i = 0; i < 4; i++) d[32*i +: 32] = $urandom;
        m = 16'($urandom);
        n = (bl == 0) ? 8 : (bl == 2) ? 4 : (x12 != 0) ? 8 : 4;
        wr(`DWB_OFS_MODE, 32'(bl + ((mm == 1) << 2) + ((mm == 2) << 3) + (dll << 5) + (al << 8) + (cwl << 16)));
        wr(`DWB_OFS_BANK, 32'hF);
        rd(`DWB_OFS_BEATS, b0);
        // stalled drain: software keeps writing array word 63 during the burst
        if (stall != 0) wr(`DWB_OFS_ARR_ADDR, 32'h0000_003F);
        fork
            ctl.burst(2'(bk), 6'(c), x10[0], x12[0], al + cwl, n, d, m);
            if (stall != 0) repeat (50) wr(`DWB_OFS_ARR_DATA, 32'h0);
        join
        if (stall != 0) exp_mem[63] = 16'h0;
        for (int i = 0; i < 40; i++) begin
            rd(`DWB_OFS_STATUS, st);
            if (st[0] === 1'b0) break;
        end
        chk("busy", 32'h0, {31'h0, st[0]});
        rd(`DWB_OFS_BEATS, b1);
        // inversion mode restores lanes sent inverted; masked lanes keep the old byte
        for (int k = 0; k < n && dll != 0; k++) begin
            for (int l = 0; l < 2; l++) begin
                lb = d[16*k + 8*l +: 8];
                if (mm == 2 && !m[2*k+l]) lb = ~lb;
                if (mm != 1 || m[2*k+l]) exp_mem[c + k][8*l +: 8] = lb;
            end
        end
        if (dll == 0) begin
            chk("ignored", 32'h1, {31'h0, st[24]});
            chk("beats", b0, b1);
            wr(`DWB_OFS_STATUS, 32'h0100_0000);
            rd(`DWB_OFS_STATUS, st);
            chk("ignored clr", 32'h0, {31'h0, st[24]});
        end else if (stall != 0) begin
            chk("ovfl", 32'h1, {31'h0, st[5] ? (b1 - b0 < n) : (b1 - b0 == n)});
        end else begin
            chk("beats", 32'(n), b1 - b0);
            chk("status", 32'(((n == 8) << 1) + (x10 << 2) + ((x10 != 0 ? 15 & ~(1 << bk) : 15) << 8)),
                st & 32'h0000_0F06);
            repeat (4) @(posedge ck);
            rd(`DWB_OFS_STATUS, s2);
            chk("recov", 32'h1, {31'h0, (s2[23:16] - st[23:16] >= 3) && (s2[23:16] - st[23:16] <= 5)});
        end
        chk_arr(c);
    endtask

    // main sequence
    initial begin
        logic [31:0] r;
        logic [4:0] f;
        logic [24:0] fl;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        void'($urandom(32'h37C225C2));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`DWB_OFS_MODE, r);
        chk("mode rst", `DWB_MODE_RST, r);
        wr(32'h0000_0018, 32'hFFFF_FFFF);
        rd(32'h0000_0018, r);
        chk("unmapped", 32'h0, r);
        for (int a = 0; a < 64; a++) begin
            exp_mem[a] = 16'($urandom);
            wr(`DWB_OFS_ARR_ADDR, 32'(a));
            wr(`DWB_OFS_ARR_DATA, {16'h0, exp_mem[a]});
        end
        do_burst(0, 0, 0, 1, 0, 1, 0, 9, 0, 0);
        do_burst(0, 0, 0, 1, 0, 1, 0, 9, 1, 0);
        do_burst(1, 1, 0, 2, 16, 1, 10, 9, 1, 0);
        do_burst(1, 1, 1, 3, 24, 0, 0, 9, 1, 0);
        do_burst(2, 0, 1, 0, 32, 2, 0, 10, 1, 0);
        do_burst(0, 0, 1, 0, 8, 0, 0, 9, 1, 1);
        // mode flags: {mask, inversion, crc, two-clock preamble, latency ten}
        fl = {5'b10100, 5'b00100, 5'b11000, 5'b00010, 5'b00011};
        for (int i = 0; i < 5; i++) begin
            f = fl[24 - 5 * i -: 5];
            wr(`DWB_OFS_MODE, 32'((f[4] << 2) + (f[3] << 3) + (f[2] << 4) + (1 << 5) + (f[1] << 6) + ((9 + f[0]) << 16)));
            rd(`DWB_OFS_STATUS, r);
            chk("flags", 32'((f[2] ? (f[4] ? 8 : 16) : 0) + ((f[4] && f[3]) ? 64 : 0) + ((f[1] && !f[0]) ? 128 : 0)),
                r & 32'h0000_00D8);
        end
        chk("hresp", 32'h0, {31'h0, hresp});
        finish_test();
    end
endmodule // ddr_write_burst_control_bench
`default_nettype wire

// file: test/dwb_ctl_model.sv
// controller-side model: free-running link clock, write commands, strobed data
`timescale 1ns/1ps
`default_nettype none
module dwb_ctl_model (
    // link pins toward the block
    output logic ck,
    output logic wr_cmd_n,
    output logic [1:0] ba,
    output logic [5:0] col,
    output logic a10,
    output logic a12,
    output logic dqs,
    output logic [15:0] dq,
    output logic [1:0] lane_ctl_n
);
    // idle levels; the link clock runs free as a real controller's does
    initial begin
        ck = 1'b0;
        wr_cmd_n = 1'b1;
        {ba, col, a10, a12, dqs, dq, lane_ctl_n} = '0;
    end
    always #80 ck = ~ck;

    // one write: command across a ck rise, wl rises, then n strobe edges
    task automatic burst(input logic [1:0] b, input logic [5:0] c, input logic x10, input logic x12,
                         input int wl, input int n, input logic [127:0] d, input logic [15:0] m);
        @(negedge ck);
        wr_cmd_n = 1'b0;
        {ba, col, a10, a12} = {b, c, x10, x12};
        @(negedge ck);
        wr_cmd_n = 1'b1;
        {ba, col} = ~{b, c}; // released fields stop holding the old value
        repeat (wl) @(posedge ck);
        // strobe edges sit 20 ns off the ck edges, rising edge first
        #20;
        for (int k = 0; k < n; k++) begin
            #40;
            dq = d[16*k +: 16];
            lane_ctl_n = m[2*k +: 2];
            #40;
            dqs = ~dqs;
        end
        #40;
        dq = ~dq;
        lane_ctl_n = ~lane_ctl_n;
        repeat (3) @(posedge ck);
    endtask
endmodule // dwb_ctl_model
`default_nettype wire

// file: verilog/dwb_mem.sv
// small array of 64 half-words with per-byte write enables
`timescale 1ns/1ps
`default_nettype none
module dwb_mem (
    // clock
    input wire logic hclk,
    // write port
    input wire logic we,
    input wire logic [1:0] be,
    input wire logic [5:0] waddr,
    input wire logic [15:0] wdata,
    // read port
    input wire logic [5:0] raddr,
    output logic [15:0] rdata_q
);
    logic [15:0] mem [0:63];

    // byte lanes written independently
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_lane
            always_ff @(posedge hclk) begin
                if (we && be[i]) begin
                    mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
        end
    endgenerate

    // registered read, one cycle behind the address
    always_ff @(posedge hclk) begin
        rdata_q <= mem[raddr];
    end
endmodule // dwb_mem
`default_nettype wire

// file: verilog/dwb_write_ctrl.sv
// write-burst command and data capture with ahb-lite registers
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dwb_cfg.svh"
module dwb_write_ctrl import dwb_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // link pins from the controller
    input wire logic ck,
    input wire logic wr_cmd_n,
    input wire logic [1:0] ba,
    input wire logic [5:0] col,
    input wire logic a10,
    input wire logic a12,
    input wire logic dqs,
    input wire logic [15:0] dq,
    input wire logic [1:0] lane_ctl_n
);
    // register index from a byte address, invalid as 3'h7
    function automatic dwb_reg_t reg_sel(input logic [31:0] a);
        case (a)
            `DWB_OFS_MODE: reg_sel = 3'h0;
            `DWB_OFS_STATUS: reg_sel = 3'h1;
            `DWB_OFS_BANK: reg_sel = 3'h2;
            `DWB_OFS_ARR_ADDR: reg_sel = 3'h3;
            `DWB_OFS_ARR_DATA: reg_sel = 3'h4;
            `DWB_OFS_BEATS: reg_sel = 3'h5;
            default: reg_sel = 3'h7;
        endcase
    endfunction

    // two-flop synchroniser on every link pin, third stage for edges
    logic [30:0] pin_s1_q, pin_s2_q;
    logic ck_s3_q, dqs_s3_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // command pin starts at its idle high level, so no phantom command
            pin_s1_q <= 31'h1000_0000;
            pin_s2_q <= 31'h1000_0000;
            ck_s3_q <= 1'b0;
            dqs_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= {ck, dqs, wr_cmd_n, ba, col, a10, a12, dq, lane_ctl_n};
            pin_s2_q <= pin_s1_q;
            ck_s3_q <= pin_s2_q[30];
            dqs_s3_q <= pin_s2_q[29];
        end
    end

    logic ck_s, dqs_s, cmd_s, a10_s, a12_s, ck_rise, dqs_edge;
    logic [1:0] ba_s, lane_s;
    logic [5:0] col_s;
    logic [15:0] dq_s;
    assign ck_s = pin_s2_q[30];
    assign dqs_s = pin_s2_q[29];
    assign cmd_s = ~pin_s2_q[28];
    assign ba_s = pin_s2_q[27:26];
    assign col_s = pin_s2_q[25:20];
    assign a10_s = pin_s2_q[19];
    assign a12_s = pin_s2_q[18];
    assign dq_s = pin_s2_q[17:2];
    assign lane_s = pin_s2_q[1:0];
    assign ck_rise = ck_s & ~ck_s3_q;
    assign dqs_edge = dqs_s ^ dqs_s3_q; // both strobe edges carry data

    // mode fields
    logic [31:0] mode_q;
    logic [1:0] bl_mode;
    logic dm_en, dbi_en, crc_en, dll_lock, pre2, dm_only, dbi_only;
    logic [4:0] al, cwl;
    logic [5:0] wl;
    assign bl_mode = mode_q[`DWB_MODE_BL_LSB +: 2];
    assign dm_en = mode_q[`DWB_MODE_DM_EN];
    assign dbi_en = mode_q[`DWB_MODE_DBI_EN];
    assign crc_en = mode_q[`DWB_MODE_CRC_EN];
    assign dll_lock = mode_q[`DWB_MODE_DLL_LOCK];
    assign pre2 = mode_q[`DWB_MODE_PRE2];
    assign al = mode_q[`DWB_MODE_AL_LSB +: 5];
    assign cwl = mode_q[`DWB_MODE_CWL_LSB +: 5];
    assign wl = {1'b0, al} + {1'b0, cwl};
    // both set is illegal; the pin then neither masks nor inverts
    assign dm_only = dm_en & ~dbi_en;
    assign dbi_only = dbi_en & ~dm_en;

    // ahb-lite address phase capture
    logic wr_pend_q;
    dwb_reg_t wr_sel_q;
    logic addr_ok;
    assign addr_ok = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_sel_q <= 3'h7;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            wr_sel_q <= reg_sel(haddr);
        end
    end

    logic sw_wr_mode, sw_wr_status, sw_wr_bank, sw_wr_aaddr, sw_wr_adata;
    assign sw_wr_mode = wr_pend_q && wr_sel_q == 3'h0;
    assign sw_wr_status = wr_pend_q && wr_sel_q == 3'h1;
    assign sw_wr_bank = wr_pend_q && wr_sel_q == 3'h2;
    assign sw_wr_aaddr = wr_pend_q && wr_sel_q == 3'h3;
    assign sw_wr_adata = wr_pend_q && wr_sel_q == 3'h4;

    // software-owned registers
    logic [5:0] arr_addr_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= `DWB_MODE_RST;
            arr_addr_q <= 6'h0;
        end else begin
            if (sw_wr_mode) begin
                mode_q <= hwdata;
            end
            if (sw_wr_aaddr) begin
                arr_addr_q <= hwdata[5:0];
            end
        end
    end

    // burst state
    dwb_state_e st_q;
    logic [5:0] lat_q, beat_col_q;
    logic [2:0] beat_q;
    logic bl8_q, autopre_q, cmd_take, burst_bl8;
    logic [1:0] bank_q;
    logic [2:0] last_beat;
    assign cmd_take = st_q == ST_IDLE && ck_rise && cmd_s && dll_lock;
    // fixed eight, or a12 picks on the fly; fixed chop otherwise
    assign burst_bl8 = bl_mode == `DWB_BL_FIXED8 || (bl_mode == `DWB_BL_OTF && a12_s);
    assign last_beat = bl8_q ? `DWB_LAST_BL8 : `DWB_LAST_BC4;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
            lat_q <= 6'h0;
            beat_q <= 3'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    lat_q <= 6'h0;
                    beat_q <= 3'h0;
                    if (cmd_take) begin
                        st_q <= (wl == 6'h0) ? ST_DATA : ST_LAT;
                    end
                end
                ST_LAT: begin
                    // the command edge is clock 0, data opens at clock wl
                    if (ck_rise) begin
                        lat_q <= lat_q + 6'h1;
                        if (lat_q + 6'h1 == wl) begin
                            st_q <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (dqs_edge) begin
                        beat_q <= beat_q + 3'h1;
                        if (beat_q == last_beat) begin
                            st_q <= ST_REC;
                        end
                    end
                end
                ST_REC: begin
                    if (ck_rise) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // command fields held for the whole burst
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bl8_q <= 1'b1;
            autopre_q <= 1'b0;
            bank_q <= 2'h0;
            beat_col_q <= 6'h0;
        end else if (cmd_take) begin
            bl8_q <= burst_bl8;
            autopre_q <= a10_s;
            bank_q <= ba_s;
            beat_col_q <= col_s;
        end
    end

    // per-lane mask or inversion on the shared pin
    dwb_beat_s push_beat;
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_lane
            // lane kept when its pin is high in mask mode
            assign push_beat.be[i] = dm_only ? lane_s[i] : 1'b1;
            assign push_beat.data[i*8 +: 8] = (dbi_only && !lane_s[i]) ? ~dq_s[i*8 +: 8] : dq_s[i*8 +: 8];
        end
    endgenerate
    assign push_beat.addr = {beat_col_q[5:3], beat_q};

    // two-entry buffer between strobe capture and the array
    dwb_beat_s buf_q [0:1];
    logic wp_q, rp_q;
    logic [1:0] cnt_q;
    logic push_v, in_ready, out_valid, out_ready, push, pop;
    assign push_v = st_q == ST_DATA && dqs_edge;
    assign in_ready = cnt_q != 2'h2;
    assign out_valid = cnt_q != 2'h0;
    assign out_ready = ~sw_wr_adata; // software array writes stall the drain
    assign push = push_v & in_ready;
    assign pop = out_valid & out_ready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge hclk) begin
        if (push) begin
            buf_q[wp_q] <= push_beat;
        end
    end

    // array write: software first, then buffer head
    dwb_beat_s head;
    logic mem_we;
    logic [1:0] mem_be;
    logic [5:0] mem_waddr;
    logic [15:0] mem_wdata, mem_rdata;
    assign head = buf_q[rp_q];
    assign mem_we = sw_wr_adata | (pop & |head.be);
    assign mem_be = sw_wr_adata ? 2'h3 : head.be;
    assign mem_waddr = sw_wr_adata ? arr_addr_q : head.addr;
    assign mem_wdata = sw_wr_adata ? hwdata[15:0] : head.data;

    dwb_mem u_mem (
        .hclk(hclk),
        .we(mem_we),
        .be(mem_be),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(arr_addr_q),
        .rdata_q(mem_rdata)
    );

    // bank open bits, recovery counter and sticky flags
    logic [3:0] bank_open_q;
    logic [7:0] recov_q;
    logic [15:0] beats_q;
    logic ovfl_q, ignored_q, conflict_q, cwl_bad_q, crc_pers_q, crc_nonp_q, rec_end;
    assign rec_end = st_q == ST_REC && ck_rise;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_open_q <= 4'h0;
            recov_q <= 8'h0;
        end else begin
            if (sw_wr_bank) begin
                bank_open_q <= hwdata[3:0]; // stand-in for activate
            end else if (rec_end && autopre_q) begin
                bank_open_q[bank_q] <= 1'b0;
            end
            // counts clock rises since the first one after the last beat
            if (rec_end) begin
                recov_q <= 8'h0;
            end else if (ck_rise && recov_q != 8'hFF) begin
                recov_q <= recov_q + 8'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovfl_q <= 1'b0;
            ignored_q <= 1'b0;
            beats_q <= 16'h0;
        end else begin
            // hardware set wins over a write-one clear
            ovfl_q <= (push_v & ~in_ready) | (ovfl_q & ~(sw_wr_status & hwdata[`DWB_ST_OVFL]));
            ignored_q <= (st_q == ST_IDLE && ck_rise && cmd_s && !dll_lock)
                | (ignored_q & ~(sw_wr_status & hwdata[`DWB_ST_IGNORED]));
            if (pop) begin
                beats_q <= beats_q + 16'h1;
            end
        end
    end

    // configuration checks and crc mode, tracked each cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conflict_q <= 1'b0;
            cwl_bad_q <= 1'b0;
            crc_pers_q <= 1'b0;
            crc_nonp_q <= 1'b0;
        end else begin
            conflict_q <= dm_en & dbi_en;
            cwl_bad_q <= pre2 && cwl <= `DWB_CWL_MIN;
            crc_pers_q <= crc_en & dm_en;
            crc_nonp_q <= crc_en & ~dm_en;
        end
    end

    // read data loaded at the address phase
    logic [31:0] status;
    always_comb begin
        status = 32'h0;
        status[`DWB_ST_BUSY] = st_q != ST_IDLE;
        status[`DWB_ST_BL8] = bl8_q;
        status[`DWB_ST_AUTOPRE] = autopre_q;
        status[`DWB_ST_CRC_PERS] = crc_pers_q;
        status[`DWB_ST_CRC_NONP] = crc_nonp_q;
        status[`DWB_ST_OVFL] = ovfl_q;
        status[`DWB_ST_CONFLICT] = conflict_q;
        status[`DWB_ST_CWL_BAD] = cwl_bad_q;
        status[`DWB_ST_BANK_LSB +: 4] = bank_open_q;
        status[`DWB_ST_RECOV_LSB +: 8] = recov_q;
        status[`DWB_ST_IGNORED] = ignored_q;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (addr_ok && !hwrite) begin
            case (reg_sel(haddr))
                3'h0: hrdata <= mode_q;
                3'h1: hrdata <= status;
                3'h2: hrdata <= {28'h0, bank_open_q};
                3'h3: hrdata <= {26'h0, arr_addr_q};
                3'h4: hrdata <= {16'h0, mem_rdata};
                3'h5: hrdata <= {16'h0, beats_q};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    // checks
    logic cur_open;
    assign cur_open = bank_open_q[bank_q];

    property p_otf_a12;
        @(posedge hclk) disable iff (!hresetn)
        (cmd_take && bl_mode == `DWB_BL_OTF) |=> (bl8_q == $past(a12_s));
    endproperty
    a_otf_a12: assert property (p_otf_a12) else $error("otf burst length not taken from a12");

    property p_fixed;
        @(posedge hclk) disable iff (!hresetn)
        (cmd_take && bl_mode != `DWB_BL_OTF) |=> (bl8_q == ($past(bl_mode) == `DWB_BL_FIXED8));
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed burst length wrong");

    property p_autopre;
        @(posedge hclk) disable iff (!hresetn)
        (rec_end && autopre_q && !sw_wr_bank) |=> !cur_open;
    endproperty
    a_autopre: assert property (p_autopre) else $error("bank not precharged after burst");

    property p_stay_open;
        @(posedge hclk) disable iff (!hresetn)
        (rec_end && !autopre_q && cur_open && !sw_wr_bank) |=> cur_open;
    endproperty
    a_stay_open: assert property (p_stay_open) else $error("bank closed by plain write");

    property p_mask;
        @(posedge hclk) disable iff (!hresetn)
        (push && dm_only) |=> (buf_q[$past(wp_q)].be == $past(lane_s));
    endproperty
    a_mask: assert property (p_mask) else $error("lane mask not honoured");

    property p_latency;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ST_LAT) |-> (lat_q < wl);
    endproperty
    a_latency: assert property (p_latency) else $error("write latency overrun");

    property p_beats;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ST_DATA && dqs_edge && beat_q == last_beat)
            |=> (st_q == ST_REC && beat_q == $past(last_beat) + 3'h1);
    endproperty
    a_beats: assert property (p_beats) else $error("burst did not end on last beat");

    property p_dll;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ST_IDLE && ck_rise && cmd_s && !dll_lock) |=> (st_q == ST_IDLE && ignored_q);
    endproperty
    a_dll: assert property (p_dll) else $error("write taken without dll lock");

    property p_recov;
        @(posedge hclk) disable iff (!hresetn)
        rec_end |=> (recov_q == 8'h0 && st_q == ST_IDLE);
    endproperty
    a_recov: assert property (p_recov) else $error("recovery not restarted after burst");

    property p_crc;
        @(posedge hclk) disable iff (!hresetn)
        crc_en ##1 (crc_en && $stable(mode_q)) |-> (crc_pers_q == dm_en && crc_nonp_q == !dm_en);
    endproperty
    a_crc: assert property (p_crc) else $error("crc mode does not follow mask enable");
endmodule // dwb_write_ctrl
`default_nettype wire
